// [adpc_ana_mdl.sv]
// Purpose: analog core and input pins behind the control block
// Assumes: bench holds the level steady through a conversion
// Notes: unpowered, the result wanders so stale data never passes
`timescale 1ns/1ps
module adpc_ana_mdl (
  input wire logic core_clk,
  input wire logic analog_power,
  input wire logic sample_en,
  input wire logic [11:0] level,
  output logic [11:0] core_result
);
  logic [11:0] held_r = 12'h5a5;
  // Track the pin while sampling, hold it for conversion
  always @(posedge core_clk) begin
    if (!analog_power) held_r <= ~held_r;
    else if (sample_en) held_r <= level;
  end
  assign core_result = held_r;
endmodule

// [adpc_chk_sva.sv]
// Purpose: port checks for the converter control
// Assumes: instruction clock counts as in the hand-over
// Notes: bound from the testbench
`timescale 1ns/1ps
`include "adpc_params.svh"
module adpc_chk
  import adpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire adpc_ctrl_t ctrl,
  input wire logic int_enable,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic [`ADPC_PINS-1:0] analog_pin_config,
  input wire logic [`ADPC_PINS-1:0] port_rd_data,
  input wire logic analog_power,
  input wire logic conv_clk_en,
  input wire logic sample_en,
  input wire logic conv_busy,
  input wire logic conv_done,
  input wire logic wake_req,
  input wire logic sleep_off
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Reset, power and clock gating
  property p_rst;
    $fell(reset) |-> !analog_power && !conv_busy && !conv_done;
  endproperty
  a_rst: assert property (p_rst) else $error("not idle after reset");
  property p_off;
    !ctrl.converter_on |=> !analog_power && !conv_busy;
  endproperty
  a_off: assert property (p_off) else $error("powered while off");
  property p_slp;
    sleep_mode && !ctrl.rc_clock_select |=> !conv_clk_en;
  endproperty
  a_slp: assert property (p_slp) else $error("clock runs in sleep");
  property p_abt;
    sleep_mode && !ctrl.rc_clock_select && conv_busy |-> ##[1:2] !conv_busy;
  endproperty
  a_abt: assert property (p_abt) else $error("no abort in sleep");
  // Sample window is four instruction cycles
  property p_smp;
    $rose(conv_busy) && !ctrl.rc_clock_select |-> sample_en [*4] ##1 !sample_en;
  endproperty
  a_smp: assert property (p_smp) else $error("sample window wrong");
  // RC source holds sampling off for one cycle after the start is taken
  property p_dly;
    $rose(conv_busy) && ctrl.rc_clock_select |-> !sample_en ##1 sample_en;
  endproperty
  a_dly: assert property (p_dly) else $error("no start delay on rc clock");
  property p_wak;
    wake_req |-> int_enable ##1 !wake_req;
  endproperty
  a_wak: assert property (p_wak) else $error("bad wake pulse");
  property p_sof;
    sleep_off |-> ##[0:1] (!analog_power && !conv_busy);
  endproperty
  a_sof: assert property (p_sof) else $error("powered after sleep end");
  property p_idl;
    idle_mode && ctrl.stop_in_idle |-> ##[1:2] !conv_clk_en;
  endproperty
  a_idl: assert property (p_idl) else $error("runs in idle");
  property p_prt;
    (port_rd_data & $past(analog_pin_config)) == '0;
  endproperty
  a_prt: assert property (p_prt) else $error("analog pin reads 1");
endmodule

// [adpc_core.sv]
// Purpose: power, sleep, idle and reset control around a 12-bit converter
// Assumes: core model delivers its result on core_result when asked
// Notes: the result buffer is not reset, so its power-on contents are unknown
`timescale 1ns/1ps
`include "adpc_params.svh"
module adpc_core
  import adpc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire adpc_ctrl_t ctrl,
  input wire logic int_enable,
  input wire logic sleep_mode,
  input wire logic idle_mode,
  input wire logic start_conv,
  input wire logic done_clear,
  input wire adpc_buf_req_t buf_req,
  input wire logic [`ADPC_IDX_W-1:0] conv_channel,
  input wire logic [`ADPC_RES_W-1:0] core_result,
  input wire logic [`ADPC_PINS-1:0] analog_pin_config,
  input wire logic [`ADPC_PINS-1:0] pin_direction,
  input wire logic [`ADPC_PINS-1:0] pin_level,
  output logic [`ADPC_BUS_W-1:0] rd_data,
  output logic [`ADPC_PINS-1:0] port_rd_data,
  output logic analog_power,
  output logic conv_clk_en,
  output logic sample_en,
  output logic conv_busy,
  output logic conv_done,
  output logic wake_req,
  output logic sleep_off
);
  adpc_state_t state_r;
  adpc_state_t state_nxt;
  logic [`ADPC_RES_W-1:0] result_buffer [`ADPC_DEPTH];
  logic [4:0] cnt_r;
  logic [3:0] dly_r;
  logic rc_tick;
  logic clocks_run;
  logic rate_en;
  logic powered;
  logic complete;
  logic sleep_abort;
  logic chan_ok;
  logic [`ADPC_BUS_W-1:0] fmt_word;

  // Clocks only run when powered, and in Sleep only on the RC source
  assign powered = ctrl.converter_on && !sleep_off;
  assign clocks_run = powered && (!sleep_mode || ctrl.rc_clock_select)
    && !(idle_mode && ctrl.stop_in_idle);
  // Instruction clock enable is the core clock; RC source is the divider
  assign rate_en = ctrl.rc_clock_select ? rc_tick : 1'b1;
  // Instruction-clock conversion caught mid-flight by Sleep is dropped
  assign sleep_abort = sleep_mode && !ctrl.rc_clock_select;
  assign complete = (state_r == ADPC_CONVERT) && rate_en && (cnt_r == 5'h00);
  // Only a pin set as analog and direction input is a real analog source;
  // selects and direction do not gate the sequence itself
  // Channel codes past the last pin never start, rather than reading an unknown bit
  assign chan_ok = (conv_channel < `ADPC_IDX_W'(`ADPC_PINS))
    && analog_pin_config[conv_channel];

  adpc_rcdiv u_rcdiv (
    .core_clk(core_clk),
    .reset(reset),
    .run(clocks_run && ctrl.rc_clock_select),
    .tick(rc_tick)
  );

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ADPC_OFF: begin
        if (powered) begin
          state_nxt = ADPC_IDLE;
        end
      end
      ADPC_IDLE: begin
        if (start_conv && clocks_run && chan_ok) begin
          state_nxt = ctrl.rc_clock_select ? ADPC_DELAY : ADPC_SAMPLE;
        end
      end
      ADPC_DELAY: begin
        if (dly_r == 4'h0) begin
          state_nxt = ADPC_SAMPLE;
        end
      end
      ADPC_SAMPLE: begin
        if (rate_en && cnt_r == 5'h00) begin
          state_nxt = ADPC_CONVERT;
        end
      end
      ADPC_CONVERT: begin
        if (complete) begin
          state_nxt = ADPC_IDLE;
        end
      end
      default: state_nxt = ADPC_OFF;
    endcase
    if (!powered) begin
      state_nxt = ADPC_OFF;
    end else if (sleep_abort && state_r != ADPC_OFF) begin
      state_nxt = ADPC_IDLE;
    end
  end

  // State register; reset powers down and aborts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_r <= ADPC_OFF;
    end else if (clocks_run || sleep_abort || !powered) begin
      state_r <= state_nxt;
    end
  end

  // One instruction-cycle start delay, then sample and convert counts
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dly_r <= 4'h0;
      cnt_r <= 5'h00;
    end else if (state_r == ADPC_IDLE && state_nxt == ADPC_DELAY) begin
      dly_r <= `ADPC_RC_DELAY_CYC - 4'h1;
    end else if (state_r == ADPC_IDLE && state_nxt == ADPC_SAMPLE) begin
      cnt_r <= `ADPC_SAMPLE_CYC;
    end else if (state_r == ADPC_DELAY && clocks_run) begin
      if (dly_r != 4'h0) begin
        dly_r <= dly_r - 4'h1;
      end else begin
        cnt_r <= `ADPC_SAMPLE_CYC;
      end
    end else if (state_r == ADPC_SAMPLE && clocks_run && rate_en) begin
      cnt_r <= (cnt_r == 5'h00) ? `ADPC_CONV_CYC : cnt_r - 5'h01;
    end else if (state_r == ADPC_CONVERT && clocks_run && rate_en && cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // Sleep power-down latch; converter-on itself is never touched
  always_ff @(posedge core_clk) begin
    if (reset || !ctrl.converter_on || !sleep_mode) begin
      sleep_off <= 1'b0;
    end else if (complete && clocks_run && !int_enable) begin
      sleep_off <= 1'b1;
    end
  end

  // Done flag: set wins over a same-cycle clear
  always_ff @(posedge core_clk) begin
    if (reset) begin
      conv_done <= 1'b0;
    end else if (complete && clocks_run) begin
      conv_done <= 1'b1;
    end else if (done_clear) begin
      conv_done <= 1'b0;
    end
  end

  // Wake pulse when a Sleep conversion finishes with interrupt enabled
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= complete && clocks_run && sleep_mode && int_enable;
    end
  end

  // Result storage has no reset so reset and Sleep leave it alone
  always_ff @(posedge core_clk) begin
    if (complete && clocks_run) begin
      result_buffer[conv_channel] <= core_result;
    end else if (buf_req.wr) begin
      result_buffer[buf_req.idx] <= buf_req.wdata[`ADPC_RES_W-1:0];
    end
  end

  adpc_fmt u_fmt (
    .fmt(ctrl.output_format_select),
    .res(result_buffer[buf_req.idx]),
    .word(fmt_word)
  );

  // Registered read data for the result buffer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rd_data <= 16'h0000;
    end else if (buf_req.rd) begin
      rd_data <= fmt_word;
    end
  end

  // Port read: analog pins read as zero; outputs convert their driven level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      port_rd_data <= '0;
    end else begin
      port_rd_data <= pin_level & ~analog_pin_config;
    end
  end

  // Status and power outputs, registered
  always_ff @(posedge core_clk) begin
    if (reset) begin
      analog_power <= 1'b0;
      conv_clk_en <= 1'b0;
      sample_en <= 1'b0;
      conv_busy <= 1'b0;
    end else begin
      analog_power <= powered;
      conv_clk_en <= clocks_run && rate_en;
      sample_en <= (state_nxt == ADPC_SAMPLE) && clocks_run;
      conv_busy <= (state_nxt == ADPC_DELAY) || (state_nxt == ADPC_SAMPLE)
        || (state_nxt == ADPC_CONVERT);
    end
  end
endmodule

// [adpc_fmt.sv]
// Purpose: present a stored 12-bit result as a 16-bit bus word
// Assumes: format codes from the params header
// Notes: pure combinational, one instance per read path
`timescale 1ns/1ps
`include "adpc_params.svh"
module adpc_fmt (
  input wire logic [1:0] fmt,
  input wire logic [`ADPC_RES_W-1:0] res,
  output logic [`ADPC_BUS_W-1:0] word
);
  // Three read views of the same stored value; both fractional codes give the same word
  always_comb begin
    unique case (fmt)
      `ADPC_FMT_INT: word = {4'h0, res};
      `ADPC_FMT_SINT: word = {{4{res[11]}}, res};
      default: word = {res, 4'h0};
    endcase
  end
endmodule

// [adpc_params.svh]
// Purpose: constants for the converter power, sleep and format control
// Assumes: 20 MHz core clock, one instruction cycle per core clock enable
// Notes: definitions only
`ifndef ADPC_PARAMS_SVH
`define ADPC_PARAMS_SVH

`define ADPC_RES_W 12
`define ADPC_BUS_W 16
`define ADPC_PINS 13
`define ADPC_DEPTH 16
`define ADPC_IDX_W 4
`define ADPC_FMT_INT 2'h0
`define ADPC_FMT_SINT 2'h1
`define ADPC_FMT_FRAC 2'h2
`define ADPC_FMT_SFRAC 2'h3
`define ADPC_RC_DIV 4'h4
`define ADPC_RC_DELAY_CYC 4'h1
`define ADPC_CONV_CYC 5'h0e
`define ADPC_SAMPLE_CYC 5'h03

`endif

// [adpc_pkg.sv]
// Purpose: shared types of the converter control block
// Assumes: constants come from adpc_params.svh
// Notes: types only
`include "adpc_params.svh"
package adpc_pkg;
  typedef struct packed {
    logic converter_on;
    logic rc_clock_select;
    logic stop_in_idle;
    logic [1:0] output_format_select;
    logic [3:0] ch0_input_select_a;
    logic [3:0] ch0_input_select_b;
  } adpc_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [`ADPC_IDX_W-1:0] idx;
    logic [`ADPC_BUS_W-1:0] wdata;
  } adpc_buf_req_t;

  typedef enum logic [4:0] {
    ADPC_OFF = 5'h01,
    ADPC_IDLE = 5'h02,
    ADPC_DELAY = 5'h04,
    ADPC_SAMPLE = 5'h08,
    ADPC_CONVERT = 5'h10
  } adpc_state_t;
endpackage

// [adpc_rcdiv.sv]
// Purpose: enable pulse standing in for the internal RC converter clock
// Assumes: core clock free running, gated by run enable
// Notes: held idle (no pulse) whenever run is low
`timescale 1ns/1ps
`include "adpc_params.svh"
module adpc_rcdiv (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic run,
  output logic tick
);
  logic [3:0] cnt_r;

  // Divider; clearing on stop keeps the clock parked at zero
  always_ff @(posedge core_clk) begin
    if (reset || !run) begin
      cnt_r <= 4'h0;
      tick <= 1'b0;
    end else if (cnt_r == `ADPC_RC_DIV - 4'h1) begin
      cnt_r <= 4'h0;
      tick <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 4'h1;
      tick <= 1'b0;
    end
  end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the converter control
// Assumes: instruction clock unless a scenario picks RC
// Notes: buffer reads checked from a queue of expected words
`timescale 1ns/1ps
`include "adpc_params.svh"
module tb;
  import adpc_pkg::*;
  logic core_clk = 0, reset = 1, int_enable = 0, sleep_mode = 0, idle_mode = 0;
  logic start_conv = 0, done_clear = 0, wk = 0;
  adpc_ctrl_t ctrl = '0;
  adpc_buf_req_t buf_req = '0;
  logic [3:0] conv_channel = 4'h5;
  logic [11:0] core_result, v, level = 12'h0;
  logic [12:0] analog_pin_config = '0, pin_level = '0, p, c;
  logic [12:0] pin_direction = '1;
  logic [15:0] rd_data;
  logic [12:0] port_rd_data;
  logic analog_power, conv_clk_en, sample_en, conv_busy, conv_done, wake_req, sleep_off;
  logic [1:0] rd_seen = 2'h0;
  logic [15:0] exp_q[$];
  int fails = 0, check_count = 0, n;
  always #25 core_clk = ~core_clk;
  adpc_core dut(.core_clk, .reset, .ctrl, .int_enable, .sleep_mode, .idle_mode, .start_conv,
    .done_clear, .buf_req, .conv_channel, .core_result, .analog_pin_config, .pin_direction,
    .pin_level, .rd_data, .port_rd_data, .analog_power, .conv_clk_en, .sample_en, .conv_busy,
    .conv_done, .wake_req, .sleep_off);
  adpc_ana_mdl u_ana(.core_clk, .analog_power, .sample_en, .level, .core_result);
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out;
    $display("fails %0d checks %0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic flag(input string nm, ref logic s, input logic e);
    @(negedge core_clk);
    chk(nm, {15'h0, s}, {15'h0, e});
    @(posedge core_clk);
  endtask
  function automatic logic [15:0] fx(input logic [1:0] f, input logic [11:0] d);
    case (f)
      `ADPC_FMT_INT: return {4'h0, d};
      `ADPC_FMT_SINT: return {{4{d[11]}}, d};
      default: return {d, 4'h0};
    endcase
  endfunction
  task automatic wr(input logic [3:0] i, input logic [15:0] d);
    @(posedge core_clk);
    buf_req <= '{1'b1, 1'b0, i, d};
    @(posedge core_clk);
    buf_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] i, input logic [1:0] f, input logic [11:0] d);
    @(posedge core_clk);
    ctrl.output_format_select <= f;
    buf_req <= '{1'b0, 1'b1, i, 16'h0};
    exp_q.push_back(fx(f, d));
    @(posedge core_clk);
    buf_req.rd <= 1'b0;
    tick(2);
  endtask
  // Start after clearing done; n counts cycles from the taking edge
  task automatic conv(input int lim, input logic s);
    @(posedge core_clk);
    done_clear <= 1'b1;
    @(posedge core_clk);
    done_clear <= 1'b0;
    start_conv <= 1'b1;
    @(posedge core_clk);
    start_conv <= 1'b0;
    sleep_mode <= s;
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (conv_done !== 1'b1 && n < lim);
  endtask
  // Read data stands until the next read, so look two edges on
  always @(posedge core_clk) rd_seen <= {rd_seen[0], buf_req.rd};
  always @(negedge core_clk) if (rd_seen[1]) chk("rd_data", rd_data, exp_q.pop_front());
  always @(posedge core_clk) if (wake_req) wk <= 1'b1;
  initial begin
    void'($urandom(59989));
    tick(20);
    reset <= 1'b0;
    for (int f = 0; f < 4; f++) begin
      v = 12'($urandom);
      wr(f[3:0], {4'($urandom), v});
      rd(f[3:0], f[1:0], v);
    end
    ctrl.converter_on <= 1'b1;
    ctrl.ch0_input_select_a <= 4'($urandom);
    analog_pin_config <= '1;
    level <= 12'($urandom);
    tick(10);
    conv(40, 1'b0);
    chk("conv_cycles", 16'(n), 16'h14);
    rd(4'h5, 2'h1, level);
    // Sleep mid-conversion on the instruction clock
    conv(8, 1'b0);
    tick(1);
    sleep_mode <= 1'b1;
    tick(30);
    sleep_mode <= 1'b0;
    tick(30);
    flag("abort", conv_done, 1'b0);
    rd(4'h5, 2'h0, level);
    ctrl.rc_clock_select <= 1'b1;
    for (int ie = 1; ie >= 0; ie--) begin
      int_enable <= ie[0];
      wk <= 1'b0;
      conv(400, 1'b1);
      flag("rc_done", conv_done, 1'b1);
      flag("wake", wk, ie[0]);
      flag("sleep_off", sleep_off, !ie[0]);
      sleep_mode <= 1'b0;
    end
    ctrl.rc_clock_select <= 1'b0;
    idle_mode <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      ctrl.stop_in_idle <= s[0];
      conv(40, 1'b0);
      flag("idle", conv_done, !s[0]);
    end
    idle_mode <= 1'b0;
    tick(40);
    // Refused: digital channel, then converter off
    analog_pin_config <= 13'h1fdf;
    conv(40, 1'b0);
    flag("digital", conv_done, 1'b0);
    analog_pin_config <= '1;
    ctrl.converter_on <= 1'b0;
    conv(40, 1'b0);
    flag("off", conv_done, 1'b0);
    // Reset mid-conversion keeps the buffer
    ctrl.converter_on <= 1'b1;
    v = 12'($urandom);
    wr(4'h3, {4'h0, v});
    conv(6, 1'b0);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    flag("rst_busy", conv_busy, 1'b0);
    rd(4'h3, 2'h0, v);
    for (int k = 0; k < 8; k++) begin
      p = 13'($urandom);
      c = 13'($urandom);
      pin_level <= p;
      analog_pin_config <= c;
      tick(2);
      @(negedge core_clk);
      chk("port", {3'h0, port_rd_data}, {3'h0, p & ~c});
    end
    close_out();
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    close_out();
  end
endmodule
bind adpc_core adpc_chk u_chk(.core_clk, .reset, .ctrl, .int_enable, .sleep_mode, .idle_mode,
  .analog_pin_config, .port_rd_data, .analog_power, .conv_clk_en, .sample_en, .conv_busy,
  .conv_done, .wake_req, .sleep_off);
